// >>> rtl/vosr_cfg.svh
// Register offsets, field positions, reset values and timing constants
`ifndef VOSR_CFG_SVH
`define VOSR_CFG_SVH

// Register offsets
`define VOSR_ADDR_FORMAT 8'h1F
`define VOSR_ADDR_CLKSYNC 8'h20
`define VOSR_ADDR_RSVD_A 8'h21
`define VOSR_ADDR_RSVD_B 8'h22
`define VOSR_ADDR_WINDOW 8'h23
`define VOSR_ADDR_STATUS 8'h24

// Output format control fields
`define VOSR_FMT_MODE_HI 7
`define VOSR_FMT_MODE_LO 5
`define VOSR_FMT_PRI_EN 4
`define VOSR_FMT_SEC_EN 3
`define VOSR_FMT_DRIVE_HI 2
`define VOSR_FMT_DRIVE_LO 1
`define VOSR_FMT_CLK_INV 0

// Output clock and sync select fields
`define VOSR_CS_CLKSEL_HI 7
`define VOSR_CS_CLKSEL_LO 6
`define VOSR_CS_HIZ_ALL 5
`define VOSR_CS_HIZ_MON 4
`define VOSR_CS_FIELD_POL 3
`define VOSR_CS_PLL_FILT 2
`define VOSR_CS_SP_REGEN 1

// Reset values
`define VOSR_RST_FORMAT 8'h94
`define VOSR_RST_CLKSYNC 8'h08
`define VOSR_RST_RSVD_A 8'h00
`define VOSR_RST_RSVD_B 8'h00
`define VOSR_RST_WINDOW 8'h0A

// Window step and activity timeout
`define VOSR_WINDOW_STEP_NS 25
`define VOSR_CLOCK_MHZ 20
`define VOSR_ACT_TIMEOUT_US 50000
`define VOSR_ACT_TIMEOUT_CYC (`VOSR_ACT_TIMEOUT_US * `VOSR_CLOCK_MHZ)

`endif

// >>> rtl/vosr_pkg.sv
// Types shared by the output and status register block
package vosr_pkg;

  typedef enum logic [2:0] {
    VOSR_MODE_RGB444 = 3'b100,
    VOSR_MODE_YCC422 = 3'b101,
    VOSR_MODE_DDR444 = 3'b110
  } vosr_mode_e;

  typedef enum logic [1:0] {
    VOSR_CLK_PIXEL = 2'b00,
    VOSR_CLK_PIXEL_90 = 2'b01,
    VOSR_CLK_PIXEL_2X = 2'b10,
    VOSR_CLK_FIXED_40M = 2'b11
  } vosr_clksel_e;

endpackage : vosr_pkg

// >>> rtl/vosr_activity_detect.sv
// Activity detector for one sync or control input pin
`timescale 1ns/10ps
`default_nettype none

module vosr_activity_detect #(
  parameter int TIMEOUT_CYC = 1000000
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Pin and status
  input wire logic i_pin,
  output logic o_active
);

  localparam int CNT_W = $clog2(TIMEOUT_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TIMEOUT_CYC - 1);

  logic sync1;
  logic sync2;
  logic sync3;
  logic level;
  logic [CNT_W-1:0] idle_count;
  logic edge_seen;

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end
    else
    begin
      sync1 <= i_pin;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Level accepted once the last two stages agree
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      level <= 1'b0;
    else if (sync2 == sync3)
      level <= sync3;
  end

  assign edge_seen = (sync2 == sync3) && (sync3 != level);

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      idle_count <= '0;
      o_active <= 1'b0;
    end
    else if (edge_seen)
    begin
      idle_count <= '0;
      o_active <= 1'b1;
    end
    else if (idle_count == CNT_LAST)
      o_active <= 1'b0;
    else
      idle_count <= idle_count + CNT_W'(1);
  end

endmodule : vosr_activity_detect

`default_nettype wire

// >>> rtl/vosr_output_stage.sv
// Output formatter: channel routing, enables and high impedance
`timescale 1ns/10ps
`default_nettype none

module vosr_output_stage #(
  parameter int DATA_W = 10
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Control
  input wire logic [2:0] i_mode,
  input wire logic i_primary_en,
  input wire logic i_secondary_en,
  input wire logic i_all_hiz,
  // Pixel data
  input wire logic [DATA_W-1:0] i_red,
  input wire logic [DATA_W-1:0] i_green,
  input wire logic [DATA_W-1:0] i_blue,
  input wire logic [DATA_W-1:0] i_secondary,
  // Pad side
  output logic [DATA_W-1:0] o_red,
  output logic [DATA_W-1:0] o_green,
  output logic [DATA_W-1:0] o_blue,
  output logic o_red_green_oe,
  output logic o_blue_oe,
  output logic o_ddr_edges
);

  logic split;

  // Split modes carry the secondary stream on blue
  assign split = (i_mode == vosr_pkg::VOSR_MODE_YCC422) ||
                 (i_mode == vosr_pkg::VOSR_MODE_DDR444);

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_red <= '0;
      o_green <= '0;
      o_blue <= '0;
    end
    else
    begin
      o_red <= i_red;
      o_green <= i_green;
      o_blue <= split ? i_secondary : i_blue;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_red_green_oe <= 1'b0;
      o_blue_oe <= 1'b0;
      o_ddr_edges <= 1'b0;
    end
    else
    begin
      o_red_green_oe <= i_primary_en && !i_all_hiz;
      o_blue_oe <= !i_all_hiz &&
        (split ? i_secondary_en : i_primary_en);
      o_ddr_edges <= (i_mode == vosr_pkg::VOSR_MODE_DDR444);
    end
  end

endmodule : vosr_output_stage

`default_nettype wire

// >>> rtl/vosr_regs.sv
// Output, sync select and input activity registers of the digitizer
//
// Behaviour
// - secondary output enable, high impedance at zero
// - split modes route secondary on blue channel
// - two-bit drive strength, resets medium high
// - output clock invert bit, resets off
// - output clock source select, resets pixel
// - global high impedance except sync monitor
// - sync monitor pin high impedance control
// - field flag polarity select, resets one
// - PLL fed raw or filtered sync
// - sync processing fed raw or regenerated sync, bit 0 written as zero
// - window width in 25 ns steps
// - line sync inputs activity status bits
// - frame sync inputs activity status bits
// - green embedded sync activity status bits
// - shared clock/hold pin activity status bit
// - clamp input activity status bit
// - output mode select, resets 4:4:4 RGB
// - primary output enable, resets enabled
`include "vosr_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module vosr_regs #(
  parameter int DATA_W = 10,
  parameter int ACT_TIMEOUT_CYC = `VOSR_ACT_TIMEOUT_CYC,
  parameter logic [7:0] RSVD_A_DEFAULT = `VOSR_RST_RSVD_A,
  parameter logic [7:0] RSVD_B_DEFAULT = `VOSR_RST_RSVD_B
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Register access from the serial port
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_hit,
  // Pixel data from the converters
  input wire logic [DATA_W-1:0] i_pix_red,
  input wire logic [DATA_W-1:0] i_pix_green,
  input wire logic [DATA_W-1:0] i_pix_blue,
  input wire logic [DATA_W-1:0] i_pix_secondary,
  // Formatted data pads
  output logic [DATA_W-1:0] o_red,
  output logic [DATA_W-1:0] o_green,
  output logic [DATA_W-1:0] o_blue,
  output logic o_red_green_oe,
  output logic o_blue_oe,
  output logic o_ddr_edges,
  output logic [1:0] o_drive_strength,
  // Output clock sources and pad
  input wire logic i_pix_clock,
  input wire logic i_pix_clock_90,
  input wire logic i_pix_clock_2x,
  input wire logic i_fixed_clock_40m,
  output logic o_clock_out,
  output logic o_clock_out_oe,
  // Field flag
  input wire logic i_field_odd,
  output logic o_field,
  output logic o_field_oe,
  // Vertical sync and sync monitor
  input wire logic i_vertical_sync,
  input wire logic i_sync_monitor,
  output logic o_vertical_sync_out,
  output logic o_vertical_sync_out_oe,
  output logic o_sync_monitor_out,
  output logic o_sync_monitor_out_oe,
  // Sync sources for PLL and sync processor
  input wire logic i_raw_sync,
  input wire logic i_filtered_sync,
  input wire logic i_regen_sync,
  output logic o_pll_sync,
  output logic o_proc_sync,
  output logic [7:0] o_window_width,
  output logic [15:0] o_window_half_ns,
  output logic [7:0] o_rsvd_a,
  output logic [7:0] o_rsvd_b,
  // Monitored pins
  input wire logic i_line_sync_in_0,
  input wire logic i_line_sync_in_1,
  input wire logic i_frame_sync_in_0,
  input wire logic i_frame_sync_in_1,
  input wire logic i_green_embedded_sync_in_0,
  input wire logic i_green_embedded_sync_in_1,
  input wire logic i_ext_clock_or_hold_in,
  input wire logic i_clamp_in
);

  logic [7:0] output_format_control;
  logic [7:0] output_clock_and_sync_select;
  logic [7:0] reserved_config_a;
  logic [7:0] reserved_config_b;
  logic [7:0] sync_filter_window_width;
  logic [7:0] input_activity_status;
  logic [7:0] monitored_pins;
  logic [7:0] next_rdata;
  logic clk_sel;
  logic hiz_all;

  // Register write strobes
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      output_format_control <= `VOSR_RST_FORMAT;
    else if (i_reg_wr && i_reg_addr == `VOSR_ADDR_FORMAT)
      output_format_control <= i_reg_wdata;
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      output_clock_and_sync_select <= `VOSR_RST_CLKSYNC;
    else if (i_reg_wr && i_reg_addr == `VOSR_ADDR_CLKSYNC)
      output_clock_and_sync_select <= {i_reg_wdata[7:1], 1'b0};
  end

  // Reserved bytes are stored as written; host keeps defaults
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      reserved_config_a <= RSVD_A_DEFAULT;
      reserved_config_b <= RSVD_B_DEFAULT;
    end
    else if (i_reg_wr && i_reg_addr == `VOSR_ADDR_RSVD_A)
      reserved_config_a <= i_reg_wdata;
    else if (i_reg_wr && i_reg_addr == `VOSR_ADDR_RSVD_B)
      reserved_config_b <= i_reg_wdata;
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      sync_filter_window_width <= `VOSR_RST_WINDOW;
    else if (i_reg_wr && i_reg_addr == `VOSR_ADDR_WINDOW)
      sync_filter_window_width <= i_reg_wdata;
  end

  // Address decode and read mux
  always_comb
  begin
    o_reg_hit = 1'b1;
    next_rdata = 8'h00;
    unique case (i_reg_addr)
      `VOSR_ADDR_FORMAT: next_rdata = output_format_control;
      `VOSR_ADDR_CLKSYNC: next_rdata = output_clock_and_sync_select;
      `VOSR_ADDR_RSVD_A: next_rdata = reserved_config_a;
      `VOSR_ADDR_RSVD_B: next_rdata = reserved_config_b;
      `VOSR_ADDR_WINDOW: next_rdata = sync_filter_window_width;
      `VOSR_ADDR_STATUS: next_rdata = input_activity_status;
      default: o_reg_hit = 1'b0;
    endcase
  end

  // Read data captured on the read strobe, no side effect
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_reg_rdata <= 8'h00;
    else if (i_reg_rd)
      o_reg_rdata <= next_rdata;
  end

  // Activity detectors, status bit order 7 down to 0
  assign monitored_pins = {
    i_line_sync_in_0, i_line_sync_in_1,
    i_frame_sync_in_0, i_frame_sync_in_1,
    i_green_embedded_sync_in_0, i_green_embedded_sync_in_1,
    i_ext_clock_or_hold_in, i_clamp_in
  };

  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : gen_detect
      vosr_activity_detect #(
        .TIMEOUT_CYC(ACT_TIMEOUT_CYC)
      ) u_detect (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_pin(monitored_pins[g]),
        .o_active(input_activity_status[g])
      );
    end
  endgenerate

  // Data formatting
  vosr_output_stage #(
    .DATA_W(DATA_W)
  ) u_output_stage (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_mode(output_format_control[`VOSR_FMT_MODE_HI:`VOSR_FMT_MODE_LO]),
    .i_primary_en(output_format_control[`VOSR_FMT_PRI_EN]),
    .i_secondary_en(output_format_control[`VOSR_FMT_SEC_EN]),
    .i_all_hiz(hiz_all),
    .i_red(i_pix_red),
    .i_green(i_pix_green),
    .i_blue(i_pix_blue),
    .i_secondary(i_pix_secondary),
    .o_red(o_red),
    .o_green(o_green),
    .o_blue(o_blue),
    .o_red_green_oe(o_red_green_oe),
    .o_blue_oe(o_blue_oe),
    .o_ddr_edges(o_ddr_edges)
  );

  assign hiz_all = output_clock_and_sync_select[`VOSR_CS_HIZ_ALL];

  // Drive strength applies to high-speed data and clock pads only
  assign o_drive_strength =
    output_format_control[`VOSR_FMT_DRIVE_HI:`VOSR_FMT_DRIVE_LO];

  // Output clock source and inversion
  always_comb
  begin
    unique case (vosr_pkg::vosr_clksel_e'(
      output_clock_and_sync_select[`VOSR_CS_CLKSEL_HI:`VOSR_CS_CLKSEL_LO]))
      vosr_pkg::VOSR_CLK_PIXEL: clk_sel = i_pix_clock;
      vosr_pkg::VOSR_CLK_PIXEL_90: clk_sel = i_pix_clock_90;
      vosr_pkg::VOSR_CLK_PIXEL_2X: clk_sel = i_pix_clock_2x;
      vosr_pkg::VOSR_CLK_FIXED_40M: clk_sel = i_fixed_clock_40m;
    endcase
  end

  assign o_clock_out =
    clk_sel ^ output_format_control[`VOSR_FMT_CLK_INV];
  assign o_clock_out_oe = !hiz_all;

  // Field flag, vertical sync and sync monitor pads
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_field <= 1'b0;
      o_vertical_sync_out <= 1'b0;
      o_sync_monitor_out <= 1'b0;
    end
    else
    begin
      o_field <= i_field_odd ^
        output_clock_and_sync_select[`VOSR_CS_FIELD_POL];
      o_vertical_sync_out <= i_vertical_sync;
      o_sync_monitor_out <= i_sync_monitor;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_field_oe <= 1'b0;
      o_vertical_sync_out_oe <= 1'b0;
      o_sync_monitor_out_oe <= 1'b0;
    end
    else
    begin
      o_field_oe <= !hiz_all;
      o_vertical_sync_out_oe <= !hiz_all;
      o_sync_monitor_out_oe <=
        !output_clock_and_sync_select[`VOSR_CS_HIZ_MON];
    end
  end

  // Sync source selection
  assign o_pll_sync = output_clock_and_sync_select[`VOSR_CS_PLL_FILT] ?
    i_filtered_sync : i_raw_sync;
  assign o_proc_sync = output_clock_and_sync_select[`VOSR_CS_SP_REGEN] ?
    i_regen_sync : i_raw_sync;

  // Window width and its half span in nanoseconds
  assign o_window_width = sync_filter_window_width;
  assign o_window_half_ns = 16'(sync_filter_window_width) *
    16'(`VOSR_WINDOW_STEP_NS);
  assign o_rsvd_a = reserved_config_a;
  assign o_rsvd_b = reserved_config_b;

endmodule : vosr_regs

`default_nettype wire

// >>> verification/vosr_regs_properties.sv
// Port assertions for the output and sync select register block
`timescale 1ns/10ps
`default_nettype none

module vosr_regs_properties #(
  parameter int DATA_W = 10
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Register port
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  // Pads
  input wire logic [DATA_W-1:0] i_pix_red,
  input wire logic [DATA_W-1:0] i_pix_secondary,
  input wire logic [DATA_W-1:0] o_red,
  input wire logic [DATA_W-1:0] o_blue,
  input wire logic o_red_green_oe,
  input wire logic [1:0] o_drive_strength,
  input wire logic o_clock_out_oe,
  input wire logic i_field_odd,
  input wire logic o_field,
  input wire logic o_field_oe,
  input wire logic o_sync_monitor_out_oe,
  // Sync selection
  input wire logic i_raw_sync,
  input wire logic i_filtered_sync,
  input wire logic i_regen_sync,
  input wire logic o_pll_sync,
  input wire logic o_proc_sync,
  input wire logic [7:0] o_window_width,
  input wire logic [15:0] o_window_half_ns
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  logic w1f;
  logic w20;
  assign w1f = i_reg_wr && i_reg_addr == 8'h1F;
  assign w20 = i_reg_wr && i_reg_addr == 8'h20;

  hiz_all_a: assert property (w20 && i_reg_wdata[5] |=> !o_clock_out_oe
    ##1 (!o_red_green_oe && !o_field_oe)) else $error("outputs not released");
  mon_hiz_a: assert property (w20 |=> ##1
    o_sync_monitor_out_oe == !$past(i_reg_wdata[4], 2))
    else $error("monitor enable wrong");
  field_pol_a: assert property (w20 |=> ##1
    o_field == ($past(i_field_odd) ^ $past(i_reg_wdata[3], 2)))
    else $error("field flag wrong");
  pll_src_a: assert property (w20 |=> o_pll_sync ==
    ($past(i_reg_wdata[2]) ? i_filtered_sync : i_raw_sync))
    else $error("pll sync source wrong");
  proc_src_a: assert property (w20 |=> o_proc_sync ==
    ($past(i_reg_wdata[1]) ? i_regen_sync : i_raw_sync))
    else $error("processing sync source wrong");
  win_width_a: assert property (i_reg_wr && i_reg_addr == 8'h23 |=>
    o_window_width == $past(i_reg_wdata) &&
    o_window_half_ns == $past(i_reg_wdata) * 16'h0019)
    else $error("window width wrong");
  drive_sel_a: assert property (w1f |=>
    o_drive_strength == $past(i_reg_wdata[2:1]))
    else $error("drive strength wrong");
  sec_route_a: assert property (w1f && i_reg_wdata[7:5] == 3'b101 |=> ##1
    (o_blue == $past(i_pix_secondary) && o_red == $past(i_pix_red)))
    else $error("split mode routing wrong");
  pri_off_a: assert property (w1f && !i_reg_wdata[4] |=> ##1
    !o_red_green_oe) else $error("primary not released");
endmodule : vosr_regs_properties

bind vosr_regs vosr_regs_properties #(.DATA_W(DATA_W)) i_props (.*);

`default_nettype wire

// >>> verification/vosr_pixel_sink.sv
// Pixel consumer model capturing the formatted pads
`timescale 1ns/10ps
`default_nettype none

module vosr_pixel_sink #(
  parameter int DATA_W = 10
) (
  // Clock
  input wire logic i_clock,
  // Pads
  input wire logic [DATA_W-1:0] i_red,
  input wire logic [DATA_W-1:0] i_blue,
  input wire logic i_red_oe,
  input wire logic i_blue_oe,
  // Captured words
  output logic [DATA_W-1:0] o_cap_red,
  output logic [DATA_W-1:0] o_cap_blue
);
  // Released pads show no stale value
  logic [DATA_W-1:0] bus_red;
  logic [DATA_W-1:0] bus_blue;
  assign bus_red = i_red_oe ? i_red : ~o_cap_red;
  assign bus_blue = i_blue_oe ? i_blue : ~o_cap_blue;

  always_ff @(posedge i_clock)
  begin
    o_cap_red <= bus_red;
    o_cap_blue <= bus_blue;
  end
endmodule : vosr_pixel_sink

`default_nettype wire

// >>> verification/vosr_regs_tb_top.sv
// Self-checking bench for the output and sync select registers
`timescale 1ns/10ps
`default_nettype none

module vosr_regs_tb_top;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00;
  logic i_reg_wr = 1'b0, i_reg_rd = 1'b0;
  logic [9:0] i_pix_red = 10'h000, i_pix_green = 10'h000;
  logic [9:0] i_pix_blue = 10'h000, i_pix_secondary = 10'h000;
  logic [3:0] csrc = 4'h0;
  logic [7:0] act = 8'h00;
  logic i_field_odd = 1'b0, i_vertical_sync = 1'b0, i_sync_monitor = 1'b0;
  logic i_raw_sync = 1'b0, i_filtered_sync = 1'b0, i_regen_sync = 1'b0;
  logic [7:0] o_reg_rdata, o_window_width, o_rsvd_a, o_rsvd_b;
  logic [9:0] o_red, o_green, o_blue, cap_r, cap_b;
  logic o_reg_hit, o_red_green_oe, o_blue_oe, o_ddr_edges, o_clock_out;
  logic o_clock_out_oe, o_field, o_field_oe, o_vertical_sync_out;
  logic o_vertical_sync_out_oe, o_sync_monitor_out, o_sync_monitor_out_oe;
  logic o_pll_sync, o_proc_sync;
  logic [1:0] o_drive_strength;
  logic [15:0] o_window_half_ns;
  int n_fail = 0;
  int cmp_count = 0;

  vosr_regs #(.ACT_TIMEOUT_CYC(16)) i_vosr_regs (
    .i_pix_clock(csrc[0]),
    .i_pix_clock_90(csrc[1]),
    .i_pix_clock_2x(csrc[2]),
    .i_fixed_clock_40m(csrc[3]),
    .i_line_sync_in_0(act[7]),
    .i_line_sync_in_1(act[6]),
    .i_frame_sync_in_0(act[5]),
    .i_frame_sync_in_1(act[4]),
    .i_green_embedded_sync_in_0(act[3]),
    .i_green_embedded_sync_in_1(act[2]),
    .i_ext_clock_or_hold_in(act[1]),
    .i_clamp_in(act[0]),
    .*
  );

  vosr_pixel_sink i_vosr_pixel_sink (
    .i_clock(i_clock),
    .i_red(o_red),
    .i_blue(o_blue),
    .i_red_oe(o_red_green_oe),
    .i_blue_oe(o_blue_oe),
    .o_cap_red(cap_r),
    .o_cap_blue(cap_b)
  );

  always #25 i_clock = ~i_clock;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrt(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_clock);
    i_reg_wr <= 1'b0;
    repeat (3) @(posedge i_clock);
    #1;
  endtask : wrt

  task automatic rck(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clock);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_clock);
    i_reg_rd <= 1'b0;
    @(posedge i_clock);
    #1;
    chk(o_reg_rdata, exp);
  endtask : rck

  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  initial
  begin
    repeat (20000) @(posedge i_clock);
    n_fail++;
    results();
  end

  initial
  begin
    repeat (20) @(posedge i_clock);
    i_rst_n <= 1'b1;
    // Reserved bytes are never written
    rck(8'h1F, 8'h94);
    rck(8'h20, 8'h08);
    rck(8'h21, 8'h00);
    rck(8'h22, 8'h00);
    rck(8'h23, 8'h0A);
    rck(8'h24, 8'h00);
    chk(o_drive_strength, 2'b10);
    chk({o_red_green_oe, o_blue_oe}, 2'b11);
    chk(o_sync_monitor_out_oe, 1'b1);
    chk({o_clock_out_oe, o_field}, 2'b11);
    chk({o_rsvd_a, o_rsvd_b}, 16'h0000);
    $display("reset test done");
    wrt(8'h23, 8'h14);
    rck(8'h23, 8'h14);
    chk(o_window_half_ns, 16'h01F4);
    chk(o_window_width, 8'h14);
    wrt(8'h24, 8'hFF);
    rck(8'h24, 8'h00);
    chk(o_reg_hit, 1'b1);
    wrt(8'h25, 8'h5A);
    rck(8'h25, 8'h00);
    chk(o_reg_hit, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      wrt(8'h1F, {5'b10010, i[1:0], 1'b0});
      chk(o_drive_strength, i[1:0]);
    end
    for (int k = 0; k < 16; k++)
    begin
      @(posedge i_clock);
      csrc <= k[3] ? 4'h3 : 4'h5;
      wrt(8'h1F, 8'h94 | k[0]);
      wrt(8'h20, {k[2:1], 6'h08});
      chk(o_clock_out, csrc[k[2:1]] ^ k[0]);
    end
    $display("register test done");
    @(posedge i_clock);
    i_pix_red <= 10'h2A5;
    i_pix_green <= 10'h0F0;
    i_pix_blue <= 10'h15A;
    i_pix_secondary <= 10'h3C3;
    wrt(8'h1F, 8'hB8);
    chk({o_red, o_blue}, {10'h2A5, 10'h3C3});
    chk(o_green, 10'h0F0);
    chk({o_blue_oe, cap_b}, {1'b1, 10'h3C3});
    wrt(8'h1F, 8'hB0);
    chk({o_red_green_oe, o_blue_oe}, 2'b10);
    wrt(8'h1F, 8'hD8);
    chk({o_ddr_edges, o_blue}, {1'b1, 10'h3C3});
    wrt(8'h1F, 8'h88);
    chk({o_red_green_oe, o_blue_oe}, 2'b00);
    chk({o_ddr_edges, o_blue}, {1'b0, 10'h15A});
    $display("routing test done");
    @(posedge i_clock);
    i_raw_sync <= 1'b1;
    i_field_odd <= 1'b1;
    i_vertical_sync <= 1'b1;
    i_sync_monitor <= 1'b1;
    wrt(8'h20, 8'h00);
    chk(o_field, 1'b1);
    chk({o_vertical_sync_out, o_vertical_sync_out_oe}, 2'b11);
    chk(o_sync_monitor_out, 1'b1);
    chk({o_pll_sync, o_proc_sync}, 2'b11);
    wrt(8'h20, 8'h06);
    chk({o_pll_sync, o_proc_sync}, 2'b00);
    wrt(8'h20, 8'h20);
    chk({o_red_green_oe, o_clock_out_oe, o_field_oe}, 3'b000);
    chk({o_blue_oe, o_vertical_sync_out_oe}, 2'b00);
    chk(o_sync_monitor_out_oe, 1'b1);
    wrt(8'h20, 8'h10);
    chk({o_sync_monitor_out_oe, o_clock_out_oe}, 2'b01);
    $display("sync select test done");
    for (int i = 0; i < 8; i++)
    begin
      @(posedge i_clock);
      act[7-i] <= 1'b1;
      repeat (6) @(posedge i_clock);
      act[7-i] <= 1'b0;
      rck(8'h24, 8'h80 >> i);
      rck(8'h24, 8'h80 >> i);
      repeat (30) @(posedge i_clock);
      rck(8'h24, 8'h00);
    end
    $display("activity test done");
    results();
  end
endmodule : vosr_regs_tb_top

`default_nettype wire
